/* rtl/sdp_op_seq.sv */
// Purpose: Operation sequencer: start, self test and pass state.
// Assumes: Engine raises engDone for one cycle when it finishes.
// Notes: Start requests while busy are ignored.
`timescale 1ns/1ns
`default_nettype none
module sdp_op_seq
  import sdp_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      sys_rst,
  input  wire logic      startReq,
  input  wire logic      clearReq,
  input  wire sdp_mode_t modeIn,
  input  wire logic      engDone,
  input  wire logic      engTestOk,
  output logic           engStart,
  output logic           busy,
  output logic           passFlag,
  output logic           failFlag,
  output logic           captureStb,
  output var sdp_mode_t  runMode
);

  sdp_state_t state_reg;
  sdp_state_t state_next;
  logic       anyMode;

  assign anyMode  = modeIn.ctr | modeIn.cbc | modeIn.aes;
  assign busy     = (state_reg != ST_IDLE);
  assign engStart = (state_reg == ST_IDLE) && startReq && (modeIn.selftest || anyMode);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (startReq && modeIn.selftest) begin
          state_next = ST_TEST;
        end else if (startReq && anyMode) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN:  if (engDone) state_next = ST_IDLE;
      ST_TEST: if (engDone) state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) state_reg <= ST_IDLE;
    else         state_reg <= state_next;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst)       runMode <= '0;
    else if (engStart) runMode <= modeIn;
  end

  // Pass flag holds zero until a self test completes successfully.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      passFlag <= 1'b0;
      failFlag <= 1'b0;
    end else if (state_reg == ST_TEST && engDone) begin
      passFlag <= engTestOk;
      failFlag <= !engTestOk;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) captureStb <= 1'b0;
    else         captureStb <= (state_reg == ST_RUN) && engDone && !clearReq;
  end

endmodule : sdp_op_seq
`default_nettype wire

/* rtl/sdp_pkg.sv */
// Purpose: Shared constants and types for the security data port.
// Assumes: Byte-wide register port with 8-bit addresses.
// Notes: One 128-bit block is seen through sixteen byte registers.
package sdp_pkg;

  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 8;
  localparam int          BLOCK_BYTES  = 16;
  localparam int          BLOCK_W      = 128;
  localparam int          NUM_SEGS     = 7;

  localparam logic [7:0]  OFS_CTRL1    = 8'h28;
  localparam logic [7:0]  OFS_CTRL2    = 8'h29;
  localparam logic [7:0]  OFS_DATA0    = 8'h2A;

  localparam int          C1_CLEAR     = 7;
  localparam int          C1_START     = 6;
  localparam int          C1_SELFTEST  = 5;
  localparam int          C1_CTR       = 4;
  localparam int          C1_CBC       = 3;
  localparam int          C1_AES       = 2;
  localparam int          C1_PRELOAD   = 1;

  localparam int          C2_SEL_LSB   = 5;
  localparam int          C2_SEL_MSB   = 7;
  localparam int          C2_PASS      = 1;

  localparam logic [7:0]  CTRL1_RST    = 8'h00;
  localparam logic [7:0]  DATA_RST     = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED  = 8'h00;

  typedef enum logic [2:0] {
    SEL_KEY     = 3'h0,
    SEL_DATA    = 3'h1,
    SEL_CTR     = 3'h2,
    SEL_CTR_RES = 3'h3,
    SEL_CBC_RES = 3'h4,
    SEL_MAC     = 3'h5,
    SEL_AES_RES = 3'h6,
    SEL_RSVD    = 3'h7
  } sdp_sel_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_TEST = 3'b100
  } sdp_state_t;

  typedef struct packed {
    logic selftest;
    logic ctr;
    logic cbc;
    logic aes;
  } sdp_mode_t;

  typedef struct packed {
    logic [BLOCK_W-1:0] key;
    logic [BLOCK_W-1:0] data;
    logic [BLOCK_W-1:0] ctr;
    logic [BLOCK_W-1:0] mac;
  } sdp_operands_t;

  typedef struct packed {
    logic [BLOCK_W-1:0] ctrRes;
    logic [BLOCK_W-1:0] cbcRes;
    logic [BLOCK_W-1:0] aesRes;
  } sdp_results_t;

endpackage : sdp_pkg

/* rtl/sdp_security_port.sv */
// Purpose: Control registers and 128-bit data window of the security module.
// Assumes: Register port is synchronous to sys_clk, one access per cycle.
// Notes: The cipher engine sits outside and is reached by the eng ports.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Selector picks segment behind data window.
// - Selector 000 reaches key storage.
// - Selector 001 reaches input data block.
// - Selector 010 reaches counter value.
// - Selector 011 shows counter-mode result.
// - Selector 100 shows CBC-MAC result.
// - Selector 101 reaches CBC-MAC starting value.
// - Selector 110 shows plain AES result.
// - Pass flag bit 1 set only on pass.
// - Failed self test forces window reads, engine operands and engine mode to zero.
// - Pass flag reads zero after reset.
// - Sixteen byte registers from 2Ah, stride one.
// - Byte n holds block bits 8n+7..8n.
// - Control two bits 4..2, 0 reserved.
// - Clear bit erases all segment memory; selector and pass flag keep their values.
// - Start bit launches enabled mode operation.
// - Self-test mode makes start run test.
// - Preload bit loads MAC starting value.
module sdp_security_port
  import sdp_pkg::*;
#(
  parameter int NSEG = NUM_SEGS
)
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic              regWrEn,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regRdEn,
  output logic      [DATA_W-1:0] regRdData,
  output logic                   regRdValid,
  output logic                   engStart,
  output var sdp_mode_t          engMode,
  output var sdp_operands_t      engOperands,
  input  wire logic              engDone,
  input  wire sdp_results_t      engResults,
  input  wire logic              engTestOk,
  output logic                   moduleBusy
);

  // Mode bits of the first control register.
  sdp_mode_t            mode_reg;
  sdp_mode_t            modeNow;

  // Window selector of the second control register.
  sdp_sel_t             sel_reg;

  // Segment storage, indexed by selector code.
  logic [BLOCK_W-1:0]   segReg [NSEG];

  logic                 wrCtrl1;
  logic                 wrCtrl2;
  logic                 clearReq;
  logic                 startReq;
  logic                 preloadReq;
  logic [BLOCK_BYTES-1:0] wrByteHit;
  logic [BLOCK_BYTES-1:0] rdByteHit;
  logic [ADDR_W-1:0]    winOfs;
  logic [3:0]           winIdx;
  logic                 winHit;
  logic                 selWritable;
  logic                 selMapped;
  logic                 passFlag;
  logic                 failFlag;
  logic                 captureStb;
  sdp_mode_t            runMode;
  logic [BLOCK_W-1:0]   selBlock;
  logic [DATA_W-1:0]    rdData_next;

  assign wrCtrl1    = regWrEn && (regAddr == OFS_CTRL1);
  assign wrCtrl2    = regWrEn && (regAddr == OFS_CTRL2);

  // Command bits act only when written as one.
  assign clearReq   = wrCtrl1 && regWrData[C1_CLEAR];
  assign startReq   = wrCtrl1 && regWrData[C1_START];
  assign preloadReq = wrCtrl1 && regWrData[C1_PRELOAD];

  // A start written together with mode bits uses the new mode.
  always_comb begin
    modeNow = mode_reg;
    if (wrCtrl1) begin
      modeNow.selftest = regWrData[C1_SELFTEST];
      modeNow.ctr      = regWrData[C1_CTR];
      modeNow.cbc      = regWrData[C1_CBC];
      modeNow.aes      = regWrData[C1_AES];
    end
  end

  // Window offset and byte index.
  assign winOfs = regAddr - OFS_DATA0;
  assign winIdx = winOfs[3:0];
  assign winHit = (regAddr >= OFS_DATA0) && (winOfs < ADDR_W'(BLOCK_BYTES));

  // Writable segments hold host inputs; result segments are read only.
  always_comb begin
    selWritable = 1'b0;
    selMapped   = 1'b1;
    case (sel_reg)
      SEL_KEY:     selWritable = 1'b1;
      SEL_DATA:    selWritable = 1'b1;
      SEL_CTR:     selWritable = 1'b1;
      SEL_CTR_RES: selWritable = 1'b0;
      SEL_CBC_RES: selWritable = 1'b0;
      SEL_MAC:     selWritable = 1'b1;
      SEL_AES_RES: selWritable = 1'b0;
      default: begin
        selWritable = 1'b0;
        selMapped   = 1'b0;
      end
    endcase
  end

  // Per-byte address decode of the data window.
  for (genvar i = 0; i < BLOCK_BYTES; i++) begin : g_byte
    localparam logic [ADDR_W-1:0] BYTE_ADDR = ADDR_W'(OFS_DATA0 + ADDR_W'(i));
    assign wrByteHit[i] = regWrEn && (regAddr == BYTE_ADDR) && selWritable;
    assign rdByteHit[i] = regRdEn && (regAddr == BYTE_ADDR) && selMapped;
  end

  // First control register: mode bits persist, command bits do not.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= sdp_mode_t'(CTRL1_RST[C1_SELFTEST:C1_AES]);
    end else if (wrCtrl1) begin
      mode_reg <= modeNow;
    end
  end

  // Second control register: only the selector is writable.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_reg <= SEL_KEY;
    end else if (wrCtrl2) begin
      sel_reg <= sdp_sel_t'(regWrData[C2_SEL_MSB:C2_SEL_LSB]);
    end
  end

  // Segment memory. Clear beats result capture, which beats preload,
  // which beats host byte writes.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int s = 0; s < NSEG; s++) begin
        segReg[s] <= '0;
      end
    end else if (clearReq) begin
      for (int s = 0; s < NSEG; s++) begin
        segReg[s] <= '0;
      end
    end else if (captureStb) begin
      if (runMode.ctr) begin
        segReg[SEL_CTR_RES] <= engResults.ctrRes;
      end
      if (runMode.cbc) begin
        segReg[SEL_CBC_RES] <= engResults.cbcRes;
      end
      if (runMode.aes) begin
        segReg[SEL_AES_RES] <= engResults.aesRes;
      end
    end else if (preloadReq) begin
      segReg[SEL_CBC_RES] <= segReg[SEL_MAC];
    end else begin
      for (int b = 0; b < BLOCK_BYTES; b++) begin
        if (wrByteHit[b]) begin
          segReg[sel_reg][b*DATA_W +: DATA_W] <= regWrData;
        end
      end
    end
  end

  // Block behind the window; a failed module shows all zero.
  always_comb begin
    selBlock = '0;
    if (selMapped && !failFlag) begin
      selBlock = segReg[sel_reg[2:0]];
    end
  end

  // Read mux for the register port.
  always_comb begin
    rdData_next = RD_UNMAPPED;
    if (regAddr == OFS_CTRL1) begin
      rdData_next = '0;
      rdData_next[C1_SELFTEST] = mode_reg.selftest;
      rdData_next[C1_CTR]      = mode_reg.ctr;
      rdData_next[C1_CBC]      = mode_reg.cbc;
      rdData_next[C1_AES]      = mode_reg.aes;
    end else if (regAddr == OFS_CTRL2) begin
      rdData_next = '0;
      rdData_next[C2_SEL_MSB:C2_SEL_LSB] = sel_reg;
      rdData_next[C2_PASS] = passFlag;
    end else if (winHit && |rdByteHit) begin
      rdData_next = selBlock[winIdx*DATA_W +: DATA_W];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= DATA_RST;
    end else if (regRdEn) begin
      regRdData <= rdData_next;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) regRdValid <= 1'b0;
    else         regRdValid <= regRdEn;
  end

  // Operation sequencer.
  sdp_op_seq u_seq (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .startReq   (startReq && !clearReq),
    .clearReq   (clearReq),
    .modeIn     (modeNow),
    .engDone    (engDone),
    .engTestOk  (engTestOk),
    .engStart   (engStart),
    .busy       (moduleBusy),
    .passFlag   (passFlag),
    .failFlag   (failFlag),
    .captureStb (captureStb),
    .runMode    (runMode)
  );

  // Operands to the engine; a failed module drives all zero.
  always_comb begin
    engOperands = '0;
    engMode     = runMode;
    if (!failFlag) begin
      engOperands.key  = segReg[SEL_KEY];
      engOperands.data = segReg[SEL_DATA];
      engOperands.ctr  = segReg[SEL_CTR];
      engOperands.mac  = segReg[SEL_CBC_RES];
    end else begin
      engMode = '0;
    end
  end

endmodule : sdp_security_port
`default_nettype wire

/* verif/sdp_host_model.sv */
// Purpose: Host side of the register port.
// Assumes: Requests change at the falling edge.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/1ns
`default_nettype none
module sdp_host_model
  import sdp_pkg::*;
(
  input  wire logic              sys_clk,
  output logic      [ADDR_W-1:0] regAddr,
  output logic                   regWrEn,
  output logic      [DATA_W-1:0] regWrData,
  output logic                   regRdEn
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge sys_clk);
    regWrEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge sys_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge sys_clk);
    regRdEn = 1'b0;
    regAddr = ~a;
  endtask : rd
endmodule : sdp_host_model
`default_nettype wire

/* verif/sdp_port_properties.sv */
// Purpose: Pin-level checks for the security data port.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Bound to every instance of the port.
`timescale 1ns/1ns
`default_nettype none
module sdp_port_properties
  import sdp_pkg::*;
#(
  parameter int NSEG = NUM_SEGS
)
(
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic              regWrEn,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic              regRdEn,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic              regRdValid,
  input wire logic              engStart,
  input wire sdp_mode_t         engMode,
  input wire sdp_operands_t     engOperands,
  input wire logic              engDone,
  input wire logic              engTestOk,
  input wire logic              moduleBusy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic ctrlWr;
  assign ctrlWr = regWrEn && (regAddr == OFS_CTRL1);
  a_read_answer: assert property (regRdEn |=> regRdValid)
    else $error("read not answered in one cycle");
  a_read_quiet: assert property (!regRdEn |=> !regRdValid && $stable(regRdData))
    else $error("read data moved without a read");
  a_start_cause: assert property (engStart |-> ctrlWr && regWrData[C1_START] && !moduleBusy)
    else $error("start pulse without an idle start write");
  a_start_busy: assert property (engStart |=> moduleBusy)
    else $error("start did not make the module busy");
  a_done_idle: assert property (moduleBusy && engDone |=> !moduleBusy)
    else $error("engine done did not end the operation");
  a_selftest_mode: assert property (engStart && regWrData[C1_SELFTEST] |=> engMode.selftest)
    else $error("start in self test mode ran no self test");
  a_clear_erase: assert property (ctrlWr && regWrData[C1_CLEAR] && !moduleBusy |=> engOperands == '0)
    else $error("clear left operands standing");
  a_reset_clean: assert property ($fell(sys_rst) |-> engOperands == '0 && engMode == '0 && !moduleBusy)
    else $error("state not clean after reset");
endmodule : sdp_port_properties
bind sdp_security_port sdp_port_properties #(.NSEG(NSEG)) chk_u (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
  .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid), .engStart(engStart),
  .engMode(engMode), .engOperands(engOperands), .engDone(engDone), .engTestOk(engTestOk),
  .moduleBusy(moduleBusy));
`default_nettype wire

/* verif/testbench.sv */
// Purpose: Self-checking bench for the security data port.
// Assumes: Engine answers are driven by the bench.
// Notes: Host accesses go through the host model.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import sdp_pkg::*;
  typedef struct packed {
    logic [2:0] sel;
    logic       wr;
    logic [7:0] base;
    logic       zero;
  } sdp_row_t;
  // Each row: selector, write first, first byte, and whether reads must come back zero.
  localparam sdp_row_t ROWS [8] = '{
    '{3'h0, 1'b1, 8'h80, 1'b0}, '{3'h1, 1'b1, 8'h90, 1'b0}, '{3'h2, 1'b1, 8'hA0, 1'b0},
    '{3'h3, 1'b1, 8'hB0, 1'b1}, '{3'h4, 1'b1, 8'hC0, 1'b1}, '{3'h5, 1'b1, 8'hD0, 1'b0},
    '{3'h6, 1'b1, 8'hE0, 1'b1}, '{3'h7, 1'b1, 8'hF0, 1'b1}};
  logic          sys_clk, sys_rst, engDone, engTestOk, regWrEn, regRdEn;
  logic          regRdValid, engStart, moduleBusy;
  logic [7:0]    regAddr, regWrData, regRdData;
  sdp_mode_t     engMode;
  sdp_operands_t engOperands;
  sdp_results_t  engResults;
  int            mismatches = 0, checkCount = 0, cycles = 0;
  sdp_host_model host_u (.sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn));
  sdp_security_port dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .engStart(engStart), .engMode(engMode),
    .engOperands(engOperands), .engDone(engDone), .engResults(engResults),
    .engTestOk(engTestOk), .moduleBusy(moduleBusy));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [127:0] blk(input logic [7:0] b);
    for (int n = 0; n < BLOCK_BYTES; n++) blk[8*n +: 8] = b + 8'(n);
  endfunction : blk
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chkb(input string what, input logic [127:0] exp, input logic [127:0] got);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chkb
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a);
    chk8("read valid", 8'h01, {7'h00, regRdValid});
    chk8(what, exp, regRdData);
  endtask : rdc
  task automatic win(input logic [2:0] s, input logic w, input logic [7:0] b, input logic z);
    host_u.wr(OFS_CTRL2, {s, 5'h00});
    for (int n = 0; n < BLOCK_BYTES; n++) if (w) host_u.wr(OFS_DATA0 + 8'(n), b + 8'(n));
    for (int n = 0; n < BLOCK_BYTES; n++) rdc("window", OFS_DATA0 + 8'(n), z ? 8'h00 : b + 8'(n));
  endtask : win
  task automatic op(input logic [7:0] cmd, input logic ok);
    host_u.wr(OFS_CTRL1, cmd);
    chk8("run mode", {4'h0, cmd[5:2]}, {4'h0, engMode});
    chk8("busy", 8'h01, {7'h00, moduleBusy});
    host_u.wr(OFS_CTRL1, cmd);
    @(negedge sys_clk);
    engDone = 1'b1;
    engTestOk = ok;
    @(negedge sys_clk);
    engDone = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : op
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    sys_rst = 1'b1;
    engDone = 1'b0;
    engTestOk = 1'b0;
    engResults = {blk(8'h30), blk(8'h50), blk(8'h70)};
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    rdc("ctrl2 after reset", OFS_CTRL2, 8'h00);
    rdc("byte after reset", OFS_DATA0 + 8'h0F, DATA_RST);
    op(8'h60, 1'b1);
    rdc("pass flag", OFS_CTRL2, 8'h02);
    foreach (ROWS[r]) win(ROWS[r].sel, ROWS[r].wr, ROWS[r].base, ROWS[r].zero);
    chkb("key operand", blk(8'h80), engOperands.key);
    chkb("data operand", blk(8'h90), engOperands.data);
    chkb("ctr operand", blk(8'hA0), engOperands.ctr);
    op(8'h58, 1'b1);
    rdc("ctrl1 modes", OFS_CTRL1, 8'h18);
    op(8'h44, 1'b1);
    win(3'h3, 1'b0, 8'h30, 1'b0);
    win(3'h4, 1'b0, 8'h50, 1'b0);
    win(3'h6, 1'b0, 8'h70, 1'b0);
    win(3'h5, 1'b1, 8'hC0, 1'b0);
    host_u.wr(OFS_CTRL1, 8'h02);
    chkb("mac operand", blk(8'hC0), engOperands.mac);
    win(3'h4, 1'b0, 8'hC0, 1'b0);
    rdc("unmapped", 8'h3A, RD_UNMAPPED);
    host_u.wr(OFS_CTRL2, 8'hFF);
    rdc("ctrl2 reserved", OFS_CTRL2, 8'hE2);
    host_u.wr(OFS_CTRL1, 8'h80);
    chkb("key cleared", '0, engOperands.key);
    win(3'h0, 1'b0, 8'h00, 1'b1);
    win(3'h0, 1'b1, 8'h80, 1'b0);
    op(8'h60, 1'b0);
    rdc("pass after fail", OFS_CTRL2, 8'h00);
    chkb("key forced", '0, engOperands.key);
    chk8("mode forced", 8'h00, {4'h0, engMode});
    win(3'h0, 1'b0, 8'h00, 1'b1);
    // A reset while idle after the failed self test must clear segments and the failed state.
    @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    rdc("ctrl2 after rerun", OFS_CTRL2, 8'h00);
    chkb("key after rerun", '0, engOperands.key);
    win(3'h0, 1'b1, 8'h80, 1'b0);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
